/* File: core/sds_pkg.sv */
// constants and types shared by the step/dir microstep sequencer
package sds_pkg;

	localparam int              ANGLE_W          = 10;
	localparam int              MAG_W            = 8;
	localparam int              IDX_W            = 8;
	localparam int              RESOLUTION_SELECT_W           = 4;
	localparam int              TABLE_DEPTH      = 256;
	localparam logic [3:0]      RESOLUTION_SELECT_MAX         = 4'h8;
	localparam logic [9:0]      STEP_UNIT        = 10'h001;
	localparam logic [9:0]      COS_OFFSET       = 10'h100;
	localparam logic [9:0]      ANGLE_RESET      = 10'h000;
	localparam int              SUB_SHIFT        = 4;
	localparam logic [4:0]      SUB_COUNT        = 5'h10;
	localparam logic [9:0]      SUB_SPAN         = 10'h010;
	localparam int              STANDSTILL_LOG2  = 20;
	localparam int              STANDSTILL_CYCLES = 1 << STANDSTILL_LOG2;
	localparam int              INTERVAL_MAX_CYCLES = 1 << STANDSTILL_LOG2;
	localparam int              IDLE_W           = 21;
	localparam int              INTERVAL_W       = 21;
	localparam int              PERIOD_W         = INTERVAL_W + SUB_SHIFT;
	localparam int              SYNC_STAGES      = 2;

	typedef enum logic {
		IPOL_IDLE = 1'b0,
		IPOL_RUN  = 1'b1
	} sds_ipol_state_t;

endpackage

/* File: core/sds_input_sync.sv */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module sds_input_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule

/* File: core/sds_step_dir_sequencer.sv */
// step/dir to microstep angle sequencer with sine lookup and interpolator
//
// Notes on behaviour
// - dual-edge select makes both step edges active
// - otherwise only rising step edges count
// - step and dir synchronised before edge detection
// - angle is a 10-bit unsigned microstep counter
// - quarter-wave table, full turn by symmetry
// - resolution select sets the step increment while interpolator off
// - dir low increments, dir high decrements
// - 256-entry table from 1 up to 248
// - peak amplitude 248 leaves offset headroom
// - angle 0 gives A its minimum of 1, B full 248
// - interpolation gives 16 fine microsteps per event
// - interpolation only while interpolator enable set
// - microstep spacing is previous period over 16
// - microstep interval capped at 2^20 - 1 clocks
// - too-slow stepping sets the standstill flag
// - next active step event clears standstill
// - early event drops remaining microsteps, angle jumps
// - standstill after 2^20 clocks with no event
// - angle msb is coil A polarity
`timescale 1ns/1ps
module sds_step_dir_sequencer #(
	parameter int STANDSTILL_CYCLES   = sds_pkg::STANDSTILL_CYCLES,
	parameter int INTERVAL_MAX_CYCLES = sds_pkg::INTERVAL_MAX_CYCLES
) (
	input  wire logic                      REF_CLK_I,
	input  wire logic                      RST_N_I,
	input  wire logic                      STEP_I,
	input  wire logic                      DIR_I,
	input  wire logic                      DUAL_EDGE_SELECT_I,
	input  wire logic [sds_pkg::RESOLUTION_SELECT_W-1:0] RESOLUTION_SELECT_I,
	input  wire logic                      INTERPOLATOR_ENABLE_I,
	output logic [sds_pkg::ANGLE_W-1:0]    MICROSTEP_ANGLE_O,
	output logic                           COIL_A_POLARITY_BIT_O,
	output logic [sds_pkg::MAG_W-1:0]      COIL_A_CURRENT_O,
	output logic                           COIL_A_NEGATIVE_O,
	output logic [sds_pkg::MAG_W-1:0]      COIL_B_CURRENT_O,
	output logic                           COIL_B_NEGATIVE_O,
	output logic                           STANDSTILL_FLAG_O
);

	localparam int ANGLE_W    = sds_pkg::ANGLE_W;
	localparam int MAG_W      = sds_pkg::MAG_W;
	localparam int IDX_W      = sds_pkg::IDX_W;
	localparam int IDLE_W     = sds_pkg::IDLE_W;
	localparam int INTERVAL_W = sds_pkg::INTERVAL_W;
	localparam int PERIOD_W   = sds_pkg::PERIOD_W;

	localparam logic [IDLE_W-1:0]     IDLE_LIMIT = IDLE_W'(STANDSTILL_CYCLES - 1);
	localparam logic [PERIOD_W-1:0]   PERIOD_MAX =
		PERIOD_W'((INTERVAL_MAX_CYCLES << sds_pkg::SUB_SHIFT) - 1);
	localparam logic [INTERVAL_W-1:0] INTERVAL_MIN = INTERVAL_W'(1);

	// first quarter of the sine, peak 248
	localparam logic [MAG_W-1:0] SINE_TABLE [sds_pkg::TABLE_DEPTH] = '{
		8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B,
		8'h0D, 8'h0E, 8'h10, 8'h11, 8'h13, 8'h15, 8'h16, 8'h18,
		8'h19, 8'h1B, 8'h1C, 8'h1E, 8'h1F, 8'h21, 8'h22, 8'h24,
		8'h25, 8'h27, 8'h28, 8'h2A, 8'h2B, 8'h2D, 8'h2E, 8'h30,
		8'h31, 8'h33, 8'h34, 8'h36, 8'h37, 8'h39, 8'h3A, 8'h3C,
		8'h3D, 8'h3E, 8'h40, 8'h41, 8'h43, 8'h44, 8'h46, 8'h47,
		8'h49, 8'h4A, 8'h4C, 8'h4D, 8'h4F, 8'h50, 8'h51, 8'h53,
		8'h54, 8'h56, 8'h57, 8'h59, 8'h5A, 8'h5B, 8'h5D, 8'h5E,
		8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h67, 8'h68, 8'h69,
		8'h6B, 8'h6C, 8'h6D, 8'h6F, 8'h70, 8'h72, 8'h73, 8'h74,
		8'h76, 8'h77, 8'h78, 8'h7A, 8'h7B, 8'h7C, 8'h7E, 8'h7F,
		8'h80, 8'h81, 8'h83, 8'h84, 8'h85, 8'h87, 8'h88, 8'h89,
		8'h8A, 8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'h91, 8'h92, 8'h93,
		8'h94, 8'h96, 8'h97, 8'h98, 8'h99, 8'h9A, 8'h9C, 8'h9D,
		8'h9E, 8'h9F, 8'hA0, 8'hA1, 8'hA3, 8'hA4, 8'hA5, 8'hA6,
		8'hA7, 8'hA8, 8'hA9, 8'hAA, 8'hAC, 8'hAD, 8'hAE, 8'hAF,
		8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB7,
		8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF,
		8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7,
		8'hC8, 8'hC9, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCE,
		8'hCF, 8'hCF, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD4,
		8'hD5, 8'hD6, 8'hD7, 8'hD7, 8'hD8, 8'hD9, 8'hDA, 8'hDA,
		8'hDB, 8'hDC, 8'hDC, 8'hDD, 8'hDE, 8'hDF, 8'hDF, 8'hE0,
		8'hE1, 8'hE1, 8'hE2, 8'hE2, 8'hE3, 8'hE4, 8'hE4, 8'hE5,
		8'hE5, 8'hE6, 8'hE7, 8'hE7, 8'hE8, 8'hE8, 8'hE9, 8'hE9,
		8'hEA, 8'hEA, 8'hEB, 8'hEB, 8'hEC, 8'hEC, 8'hED, 8'hED,
		8'hEE, 8'hEE, 8'hEE, 8'hEF, 8'hEF, 8'hF0, 8'hF0, 8'hF0,
		8'hF1, 8'hF1, 8'hF1, 8'hF2, 8'hF2, 8'hF2, 8'hF3, 8'hF3,
		8'hF3, 8'hF4, 8'hF4, 8'hF4, 8'hF4, 8'hF5, 8'hF5, 8'hF5,
		8'hF5, 8'hF6, 8'hF6, 8'hF6, 8'hF6, 8'hF6, 8'hF7, 8'hF7,
		8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF8, 8'hF8,
		8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8
	};

	// dir low moves up, dir high moves down, wrapping mod 1024
	function automatic logic [ANGLE_W-1:0] step_angle(
		input logic [ANGLE_W-1:0] angle,
		input logic               down,
		input logic [ANGLE_W-1:0] amount
	);
		if (down) begin
			step_angle = angle - amount;
		end else begin
			step_angle = angle + amount;
		end
	endfunction

	// returns {negative, magnitude} of the sine at this angle
	function automatic logic [MAG_W:0] sine_lookup(
		input logic [ANGLE_W-1:0] angle
	);
		logic [IDX_W-1:0] idx;
		idx = angle[IDX_W-1:0];
		if (angle[IDX_W]) begin
			idx = ~idx;
		end
		sine_lookup = {angle[ANGLE_W-1], SINE_TABLE[idx]};
	endfunction

	logic [1:0]                sync_w;
	logic                      step_s;
	logic                      dir_s;
	logic                      step_prev_q;
	logic                      step_rise;
	logic                      step_fall;
	logic                      step_event;
	logic [sds_pkg::RESOLUTION_SELECT_W-1:0] resolution_select_eff;
	logic [ANGLE_W-1:0]        step_size;
	logic [IDLE_W-1:0]         idle_q;
	logic                      standstill_set;
	logic                      standstill_q;
	logic [PERIOD_W-1:0]       period_q;
	logic [INTERVAL_W-1:0]     interval_d;
	logic [INTERVAL_W-1:0]     interval_q;
	logic [INTERVAL_W-1:0]     tick_q;
	logic                      tick_done;
	logic [4:0]                remaining_q;
	logic                      ipol_dir_q;
	sds_pkg::sds_ipol_state_t  ipol_state_q;
	logic [ANGLE_W-1:0]        angle_q;
	logic [ANGLE_W-1:0]        target_q;
	logic [MAG_W:0]            coil_a_w;
	logic [MAG_W:0]            coil_b_w;
	logic [MAG_W-1:0]          coil_a_mag_q;
	logic [MAG_W-1:0]          coil_b_mag_q;
	logic                      coil_a_neg_q;
	logic                      coil_b_neg_q;

	// pins are asynchronous to the system clock
	sds_input_sync #(
		.WIDTH (sds_pkg::SYNC_STAGES)
	) u_input_sync (
		.clk_i   (REF_CLK_I),
		.rst_n_i (RST_N_I),
		.async_i ({DIR_I, STEP_I}),
		.sync_o  (sync_w)
	);

	assign step_s = sync_w[0];
	assign dir_s  = sync_w[1];

	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			step_prev_q <= 1'b0;
		end else begin
			step_prev_q <= step_s;
		end
	end

	assign step_rise = step_s & ~step_prev_q;
	assign step_fall = ~step_s & step_prev_q;

	assign step_event = DUAL_EDGE_SELECT_I ? (step_rise | step_fall) : step_rise;

	// codes above full step clamp to full step
	assign resolution_select_eff  = (RESOLUTION_SELECT_I > sds_pkg::RESOLUTION_SELECT_MAX) ?
		sds_pkg::RESOLUTION_SELECT_MAX : RESOLUTION_SELECT_I;
	assign step_size = sds_pkg::STEP_UNIT << resolution_select_eff;

	// cycles since the last active event, saturating
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			idle_q <= '0;
		end else if (step_event) begin
			idle_q <= '0;
		end else if (idle_q != IDLE_LIMIT) begin
			idle_q <= idle_q + IDLE_W'(1);
		end
	end

	// a held level would also beat the clearing event, so set only once
	assign standstill_set = (idle_q == IDLE_LIMIT) && !standstill_q;

	// set wins over the clearing event
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			standstill_q <= 1'b0;
		end else if (standstill_set) begin
			standstill_q <= 1'b1;
		end else if (step_event) begin
			standstill_q <= 1'b0;
		end
	end

	// step period in clocks, restarted by each event
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			period_q <= PERIOD_MAX;
		end else if (step_event) begin
			period_q <= PERIOD_W'(1);
		end else if (period_q != PERIOD_MAX) begin
			period_q <= period_q + PERIOD_W'(1);
		end
	end

	// one sixteenth of the period, never zero, capped by saturation
	always_comb begin
		interval_d = period_q[PERIOD_W-1:sds_pkg::SUB_SHIFT];
		if (interval_d == '0) begin
			interval_d = INTERVAL_MIN;
		end
	end

	assign tick_done = (tick_q == interval_q - INTERVAL_MIN);

	// interpolator sequencing; a new event restarts the burst
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			ipol_state_q <= sds_pkg::IPOL_IDLE;
			remaining_q  <= '0;
			tick_q       <= '0;
			interval_q   <= INTERVAL_MIN;
			ipol_dir_q   <= 1'b0;
		end else if (step_event && INTERPOLATOR_ENABLE_I) begin
			ipol_state_q <= sds_pkg::IPOL_RUN;
			remaining_q  <= sds_pkg::SUB_COUNT;
			tick_q       <= '0;
			interval_q   <= interval_d;
			ipol_dir_q   <= dir_s;
		end else if (step_event || !INTERPOLATOR_ENABLE_I) begin
			ipol_state_q <= sds_pkg::IPOL_IDLE;
			remaining_q  <= '0;
			tick_q       <= '0;
		end else begin
			unique case (ipol_state_q)
				sds_pkg::IPOL_IDLE: begin
					tick_q <= '0;
				end
				sds_pkg::IPOL_RUN: begin
					if (tick_done) begin
						tick_q      <= '0;
						remaining_q <= remaining_q - 5'h01;
						if (remaining_q == 5'h01) begin
							ipol_state_q <= sds_pkg::IPOL_IDLE;
						end
					end else begin
						tick_q <= tick_q + INTERVAL_W'(1);
					end
				end
			endcase
		end
	end

	// angle counter and end-of-burst target
	// leftover fine steps are dropped by jumping to the old target first
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			angle_q  <= sds_pkg::ANGLE_RESET;
			target_q <= sds_pkg::ANGLE_RESET;
		end else if (step_event && INTERPOLATOR_ENABLE_I) begin
			// finish the previous burst at once
			angle_q  <= target_q;
			// burst spans sixteen 1/256 steps; input assumed 16x
			target_q <= step_angle(target_q, dir_s, sds_pkg::SUB_SPAN);
		end else if (step_event) begin
			angle_q  <= step_angle(angle_q, dir_s, step_size);
			target_q <= step_angle(angle_q, dir_s, step_size);
		end else if (ipol_state_q == sds_pkg::IPOL_RUN && INTERPOLATOR_ENABLE_I) begin
			if (tick_done) begin
				angle_q <= step_angle(angle_q, ipol_dir_q, sds_pkg::STEP_UNIT);
			end
		end else begin
			// interpolator off mid-burst: land on the committed target
			angle_q <= target_q;
		end
	end

	// coil A sine, coil B cosine via a quarter-turn offset
	assign coil_a_w = sine_lookup(angle_q);
	assign coil_b_w = sine_lookup(angle_q + sds_pkg::COS_OFFSET);

	// registered currents lag the angle by one clock
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			coil_a_mag_q <= '0;
			coil_b_mag_q <= '0;
			coil_a_neg_q <= 1'b0;
			coil_b_neg_q <= 1'b0;
		end else begin
			coil_a_mag_q <= coil_a_w[MAG_W-1:0];
			coil_a_neg_q <= coil_a_w[MAG_W];
			coil_b_mag_q <= coil_b_w[MAG_W-1:0];
			coil_b_neg_q <= coil_b_w[MAG_W];
		end
	end

	assign MICROSTEP_ANGLE_O     = angle_q;
	// msb gives coil A current direction
	assign COIL_A_POLARITY_BIT_O = angle_q[ANGLE_W-1];
	assign COIL_A_CURRENT_O      = coil_a_mag_q;
	assign COIL_A_NEGATIVE_O     = coil_a_neg_q;
	assign COIL_B_CURRENT_O      = coil_b_mag_q;
	assign COIL_B_NEGATIVE_O     = coil_b_neg_q;
	assign STANDSTILL_FLAG_O     = standstill_q;

endmodule

/* File: dv/sds_seq_props.sv */
// checker of the step/dir microstep sequencer, bound to its top
`timescale 1ns/1ps
module sds_seq_props #(
	parameter int STANDSTILL_CYCLES   = 64,
	parameter int INTERVAL_MAX_CYCLES = 64
) (
	input wire logic       REF_CLK_I,
	input wire logic       RST_N_I,
	input wire logic       STEP_I,
	input wire logic       DIR_I,
	input wire logic       DUAL_EDGE_SELECT_I,
	input wire logic [3:0] RESOLUTION_SELECT_I,
	input wire logic       INTERPOLATOR_ENABLE_I,
	input wire logic [9:0] MICROSTEP_ANGLE_O,
	input wire logic       COIL_A_POLARITY_BIT_O,
	input wire logic [7:0] COIL_A_CURRENT_O,
	input wire logic       COIL_A_NEGATIVE_O,
	input wire logic [7:0] COIL_B_CURRENT_O,
	input wire logic       COIL_B_NEGATIVE_O,
	input wire logic       STANDSTILL_FLAG_O
);
	logic [2:0] stp_q;
	logic [1:0] dir_q;
	logic [9:0] sz;
	logic       ev;
	int         idle_q;
	// same depth as the pin synchroniser, so events line up
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			stp_q <= 3'h0;
			dir_q <= 2'h0;
		end else begin
			stp_q <= {stp_q[1:0], STEP_I};
			dir_q <= {dir_q[0], DIR_I};
		end
	end
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I || ev) idle_q <= 0;
		else if (idle_q < STANDSTILL_CYCLES) idle_q <= idle_q + 1;
	end
	assign ev = DUAL_EDGE_SELECT_I ? stp_q[1] ^ stp_q[2] : stp_q[1] & ~stp_q[2];
	assign sz = 10'h001 << ((RESOLUTION_SELECT_I > 4'h8) ? 4'h8 : RESOLUTION_SELECT_I);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);
	chk_idle_hold: assert property (!ev && !INTERPOLATOR_ENABLE_I &&
		!$past(INTERPOLATOR_ENABLE_I) && !$past(INTERPOLATOR_ENABLE_I, 2)
		|=> $stable(MICROSTEP_ANGLE_O)) else $error("angle moved without step event");
	chk_step_size: assert property (ev && !INTERPOLATOR_ENABLE_I &&
		!$past(INTERPOLATOR_ENABLE_I) |=> MICROSTEP_ANGLE_O == ($past(dir_q[1]) ?
		$past(MICROSTEP_ANGLE_O) - $past(sz) : $past(MICROSTEP_ANGLE_O) + $past(sz)))
		else $error("angle step size or direction wrong");
	chk_a_sign: assert property ($past(RST_N_I) |->
		COIL_A_NEGATIVE_O == $past(MICROSTEP_ANGLE_O[9]) &&
		COIL_A_POLARITY_BIT_O == MICROSTEP_ANGLE_O[9]) else $error("coil a polarity wrong");
	chk_b_sign: assert property ($past(RST_N_I) |->
		COIL_B_NEGATIVE_O == $past(MICROSTEP_ANGLE_O[9] ^ MICROSTEP_ANGLE_O[8]))
		else $error("coil b polarity wrong");
	chk_peak_limit: assert property (COIL_A_CURRENT_O <= 8'hF8 &&
		COIL_B_CURRENT_O <= 8'hF8) else $error("coil current above peak");
	chk_quadrant_ends: assert property (MICROSTEP_ANGLE_O[7:0] == 8'h00 |=>
		COIL_A_CURRENT_O == ($past(MICROSTEP_ANGLE_O[8]) ? 8'hF8 : 8'h01) &&
		COIL_B_CURRENT_O == ($past(MICROSTEP_ANGLE_O[8]) ? 8'h01 : 8'hF8))
		else $error("quadrant end currents wrong");
	chk_standstill_time: assert property ($rose(STANDSTILL_FLAG_O) |->
		idle_q == STANDSTILL_CYCLES || $past(idle_q) == STANDSTILL_CYCLES - 1)
		else $error("standstill flag at wrong time");
	chk_standstill_clear: assert property (ev &&
		idle_q != STANDSTILL_CYCLES - 1 |=> !STANDSTILL_FLAG_O) else $error("standstill kept");
	chk_fine_steps: assert property (INTERPOLATOR_ENABLE_I &&
		$past(INTERPOLATOR_ENABLE_I) && !ev |=> (MICROSTEP_ANGLE_O - $past(MICROSTEP_ANGLE_O))
		inside {10'h000, 10'h001, 10'h3FF}) else $error("fine step larger than one");
endmodule
bind sds_step_dir_sequencer sds_seq_props #(
	.STANDSTILL_CYCLES  (STANDSTILL_CYCLES),
	.INTERVAL_MAX_CYCLES(INTERVAL_MAX_CYCLES)
) u_props (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .STEP_I(STEP_I), .DIR_I(DIR_I),
	.DUAL_EDGE_SELECT_I(DUAL_EDGE_SELECT_I), .RESOLUTION_SELECT_I(RESOLUTION_SELECT_I),
	.INTERPOLATOR_ENABLE_I(INTERPOLATOR_ENABLE_I), .MICROSTEP_ANGLE_O(MICROSTEP_ANGLE_O),
	.COIL_A_POLARITY_BIT_O(COIL_A_POLARITY_BIT_O), .COIL_A_CURRENT_O(COIL_A_CURRENT_O),
	.COIL_A_NEGATIVE_O(COIL_A_NEGATIVE_O), .COIL_B_CURRENT_O(COIL_B_CURRENT_O),
	.COIL_B_NEGATIVE_O(COIL_B_NEGATIVE_O), .STANDSTILL_FLAG_O(STANDSTILL_FLAG_O));

/* File: dv/sds_step_src.sv */
// step and direction source standing in for the outside controller
`timescale 1ns/1ps
module sds_step_src (
	input  wire logic clk_i,
	input  wire logic fire_i,
	input  wire logic dir_i,
	output logic      step_o,
	output logic      dir_o
);
	logic [1:0] wait_q;
	initial begin
		step_o = 1'h0;
		dir_o = 1'h0;
		wait_q = 2'h0;
	end
	// dir set up first, caller spaces edges
	always @(posedge clk_i) begin
		if (fire_i) begin
			dir_o <= dir_i;
			wait_q <= 2'h3;
		end else if (wait_q != 2'h0) begin
			wait_q <= wait_q - 2'h1;
			if (wait_q == 2'h1) step_o <= ~step_o;
		end
	end
endmodule

/* File: dv/test_step_dir_microstep_sequencer.sv */
// self-checking bench for the step/dir microstep sequencer
`timescale 1ns/1ps
module test_step_dir_microstep_sequencer;
	localparam int LIM = 64;
	logic       clk, rst_n, fire, dir_req, step, dir, dual, ipol, pol, a_neg, b_neg, standstill_flag;
	logic [3:0] res;
	logic [9:0] angle, exp_a;
	logic [7:0] a_cur, b_cur;
	int         err_total, n_tests, i;
	// rows: dual, dir, resolution, angle change for two toggles
	logic [15:0] rows [8] = '{16'h0001, 16'h47FE, 16'h9020, 16'hDF00,
		16'h2100, 16'h6700, 16'hBE00, 16'h0C08};
	sds_step_dir_sequencer #(.STANDSTILL_CYCLES(LIM), .INTERVAL_MAX_CYCLES(LIM)) uut (
		.REF_CLK_I(clk), .RST_N_I(rst_n), .STEP_I(step), .DIR_I(dir),
		.DUAL_EDGE_SELECT_I(dual), .RESOLUTION_SELECT_I(res), .INTERPOLATOR_ENABLE_I(ipol),
		.MICROSTEP_ANGLE_O(angle), .COIL_A_POLARITY_BIT_O(pol), .COIL_A_CURRENT_O(a_cur),
		.COIL_A_NEGATIVE_O(a_neg), .COIL_B_CURRENT_O(b_cur), .COIL_B_NEGATIVE_O(b_neg),
		.STANDSTILL_FLAG_O(standstill_flag));
	sds_step_src u_src (.clk_i(clk), .fire_i(fire), .dir_i(dir_req), .step_o(step), .dir_o(dir));
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] s);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one step pin toggle, slow enough for the synchroniser
	task automatic edge_go(input logic d);
		fire <= 1'h1;
		dir_req <= d;
		@(posedge clk);
		fire <= 1'h0;
		repeat (11) @(posedge clk);
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		wrap_up();
	end
	initial begin
		{rst_n, fire, dir_req, dual, ipol, res} = 9'h000;
		err_total = 0;
		n_tests = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge clk);
		chk("reset coil a", 10'h001, {2'h0, a_cur});
		chk("reset coil b", 10'h0F8, {2'h0, b_cur});
		exp_a = 10'h000;
		for (i = 0; i < 8; i++) begin
			{dual, res} <= {rows[i][15], rows[i][13:10]};
			@(posedge clk);
			repeat (2) edge_go(rows[i][14]);
			exp_a = exp_a + rows[i][9:0];
			chk("angle", exp_a, angle);
		end
		// angle now 0x127: mirrored index in the second quarter
		chk("coil a", 10'h0F1, {2'h0, a_cur});
		chk("coil b", 10'h03C, {2'h0, b_cur});
		chk("signs", 10'h001, {8'h00, a_neg, b_neg});
		chk("polarity", 10'h000, {9'h000, pol});
		repeat (80) @(posedge clk);
		chk("standstill", 10'h001, {9'h000, standstill_flag});
		{dual, res} <= 5'h00;
		@(posedge clk);
		edge_go(1'h0);
		chk("standstill", 10'h000, {9'h000, standstill_flag});
		chk("angle", 10'h128, angle);
		ipol <= 1'h1;
		dual <= 1'h1;
		for (i = 0; i < 4; i++) begin
			edge_go(1'h0);
			repeat (40) @(posedge clk);
		end
		// early event cuts the burst short: 10 of 16 fine steps done
		edge_go(1'h0);
		repeat (20) @(posedge clk);
		edge_go(1'h1);
		// jump to 0x178, then two fine steps down at the new spacing of 2
		chk("cut burst", 10'h176, angle);
		repeat (150) @(posedge clk);
		chk("fine angle", 10'h168, angle);
		wrap_up();
	end
endmodule
